// file: emi_consts.svh
// Constants for the external memory interface setup block.
// Assumes inclusion by bare name from the design file.
`ifndef EMI_CONSTS_SVH
`define EMI_CONSTS_SVH
// Register indices; the bus byte address is four times the index
`define EMI_IDX_GCTL1 16'h0800
`define EMI_IDX_GCTL2 16'h0801
`define EMI_IDX_S0T1 16'h0804
`define EMI_IDX_S0T2 16'h0805
`define EMI_IDX_FLT1 16'h0808
`define EMI_IDX_FLT2 16'h0809
`define EMI_IDX_LGT1 16'h080A
`define EMI_IDX_LGT2 16'h080B
`define EMI_IDX_DRC1 16'h080C
`define EMI_IDX_DRC2 16'h080D
`define EMI_IDX_RFP 16'h080E
`define EMI_IDX_RFX 16'h080F
`define EMI_IDX_EXT1 16'h0810
`define EMI_IDX_EXT2 16'h0811
`define EMI_IDX_CLKPLAN 16'h0820
`define EMI_IDX_STATUS 16'h0821
// Reset and kernel values
`define EMI_RST_GCTL1 16'h07FC
`define EMI_RST_GCTL2 16'h000A
`define EMI_RST_S0T1 16'hFF33
`define EMI_RST_S0T2 16'hFFFF
`define EMI_RST_FLT1 16'hC811
`define EMI_RST_FLT2 16'h11E2
`define EMI_RST_LGT1 16'hC422
`define EMI_RST_LGT2 16'h2122
`define EMI_RST_DRC1 16'h5000
`define EMI_RST_DRC2 16'h4611
`define EMI_INIT_DRC2 16'h4711
`define EMI_RST_RFP 16'h0494
`define EMI_RST_RFX 16'h0000
`define EMI_RST_EXT1 16'h4527
`define EMI_RST_EXT2 16'h0005
// Field positions
`define EMI_GC1_NO_HOLD_ENABLE 7
`define EMI_GC1_FIRST_MEMCLK_FLOAT_POS 6
`define EMI_GC1_FIRST_MEMCLK_ENABLE_POS 5
`define EMI_GC2_RATE_LSB 2
`define EMI_GC2_HZ_POS 1
`define EMI_GC2_EN_POS 0
`define EMI_MEMORY_TYPE_FIELD_LSB 4
`define EMI_DRC2_REFRESH_ENABLE_BIT_POS 9
`define EMI_DRC2_INIT_POS 8
`define EMI_DRC1_SELF_REFRESH_REQUEST_POS 11
// Clock plan in MHz
`define EMI_XTAL_MHZ 20
`define EMI_BOOT_PERIPH_MHZ 5
`define EMI_CORE_MHZ 300
`define EMI_FAST_MHZ 150
`define EMI_SLOW_MHZ 75
`define EMI_MEM_DIV 4
`define EMI_DRAM_MAX_MHZ 100
`define EMI_ALT_CORE_MHZ 200
`define EMI_ALT_DIV 2
// Address map (byte addresses, 24 bits)
`define EMI_DRAM_LO 24'h010000
`define EMI_DRAM_HI 24'h3FFFFF
`define EMI_FLASH_LO 24'h800000
`define EMI_FLASH_HI 24'h9FFFFF
`define EMI_LOGIC_LO 24'hC00000
`define EMI_LOGIC_HI 24'hFFFFFF
`define EMI_FLASH_SECTOR_WORDS 32768
`define EMI_FLASH_SECTORS 32
`endif

// file: emi_pkg.sv
// Types shared by the external memory interface setup block.
// Assumes emi_consts.svh sits in the include path.
package emi_pkg;
  typedef enum logic [2:0] {
    EMI_SP_NONE = 3'h0,
    EMI_SP_DRAM = 3'h1,
    EMI_SP_FLASH = 3'h2,
    EMI_SP_LOGIC = 3'h4
  } emi_space_e;
  typedef enum logic [3:0] {
    EMI_ST_IDLE = 4'h1,
    EMI_ST_ACC = 4'h2,
    EMI_ST_PAIR = 4'h4,
    EMI_ST_DONE = 4'h8
  } emi_state_e;
  // Core-side access request
  typedef struct packed {
    logic [23:0] addr;
    logic write;
    logic [31:0] wdata;
  } emi_req_s;
  // Clock plan in MHz
  typedef struct packed {
    logic [8:0] core_mhz;
    logic [8:0] fast_mhz;
    logic [8:0] slow_mhz;
    logic [8:0] mem_mhz;
    logic [8:0] dram_clk_mhz;
  } emi_clk_s;
endpackage : emi_pkg

// file: emi_setup.sv
// External memory interface setup: register file over AXI4-Lite,
// clock plan, space decode and per-access sequencing toward memories.
// Assumes a 10 MHz clk, synchronous active-low reset, pins from outside.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "emi_consts.svh"

// Functional notes
// - After reset core 20, others 5 MHz
// - Kernel sets 300/150/75/75 MHz plan
// - Memory interface runs at core over four (code keeps 75 at core 200)
// - DRAM on space zero, 10000-3FFFFF
// - Only lower half DRAM reachable
// - DRAM clock quarter core, half at 200
// - Flash on space two from 800000
// - Flash has 32 sectors of 32k words
// - Inverted flash ready/busy drives interrupt one
// - Flash single read fetches paired word
// - Flash writes make exactly one access
// - Global control one is 0x07FC
// - Global control two is 0x000A
// - Space zero words FF33 and FFFF
// - Flash space words C811 and 11E2
// - Logic space words C422 and 2122
// - DRAM control one is 0x5000
// - DRAM control two 4611, 4711 init
// - Refresh every 1172 memory clocks
// - DRAM extension one is 0x4527
// - DRAM extension two is 0x0005
// - Processor reset low resets this logic
// - Logic space from C00000, single read
module emi_setup
  import emi_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire emi_req_s core_req,
  input wire logic core_req_valid,
  output logic core_req_ready,
  output logic [2:0] mem_space_select,
  output logic mem_strobe,
  output logic mem_write,
  output logic [23:0] mem_addr,
  output logic core_done,
  input wire logic flash_ready_busy,
  output logic flash_done_interrupt,
  output logic [4:0] flash_sector,
  output logic refresh_request,
  output logic dram_clock_enable,
  output emi_clk_s clk_plan
);

  // Register index and address helper
  function automatic logic [15:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = 16'(a >> 2);
  endfunction : reg_idx

  // Space decode, used by the sequencer for the access address
  function automatic emi_space_e space_of(input logic [23:0] a);
    if (a >= `EMI_DRAM_LO && a <= `EMI_DRAM_HI)
      space_of = EMI_SP_DRAM;
    else if (a >= `EMI_FLASH_LO && a <= `EMI_FLASH_HI)
      space_of = EMI_SP_FLASH;
    else if (a >= `EMI_LOGIC_LO && a <= `EMI_LOGIC_HI)
      space_of = EMI_SP_LOGIC;
    else
      space_of = EMI_SP_NONE;
  endfunction : space_of

  logic [15:0] global_control_one;
  logic [15:0] global_control_two;
  logic [15:0] space0_timing_one;
  logic [15:0] space0_timing_two;
  logic [15:0] flash_space_timing_one;
  logic [15:0] flash_space_timing_two;
  logic [15:0] logic_space_timing_one;
  logic [15:0] logic_space_timing_two;
  logic [15:0] dram_control_one;
  logic [15:0] dram_control_two;
  logic [15:0] dram_refresh_period;
  logic [15:0] dram_refresh_extra;
  logic [15:0] dram_extension_one;
  logic [15:0] dram_extension_two;
  logic [1:0] clock_plan_sel;
  logic aw_held;
  logic w_held;
  logic [15:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic rdy_s1;
  logic rdy_s2;
  logic [15:0] refresh_count;
  emi_state_e state;
  emi_req_s cur;
  logic [1:0] paired_left;
  logic wr_fire;

  // Address and data are caught separately, in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Write channel capture
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 16'h0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_idx <= reg_idx(s_axi_awaddr);
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else if (clk_en)
    begin
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_idx) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic mapped(input logic [15:0] i);
    if ((i >= `EMI_IDX_GCTL1 && i <= `EMI_IDX_GCTL2) ||
        (i >= `EMI_IDX_S0T1 && i <= `EMI_IDX_S0T2) ||
        (i >= `EMI_IDX_FLT1 && i <= `EMI_IDX_EXT2) ||
        (i >= `EMI_IDX_CLKPLAN && i <= `EMI_IDX_STATUS))
      mapped = 1'b1;
    else
      mapped = 1'b0;
  endfunction : mapped

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // Register file; reset holds the kernel setup values
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      global_control_one <= `EMI_RST_GCTL1;
      global_control_two <= `EMI_RST_GCTL2;
      space0_timing_one <= `EMI_RST_S0T1;
      space0_timing_two <= `EMI_RST_S0T2;
      flash_space_timing_one <= `EMI_RST_FLT1;
      flash_space_timing_two <= `EMI_RST_FLT2;
      logic_space_timing_one <= `EMI_RST_LGT1;
      logic_space_timing_two <= `EMI_RST_LGT2;
      dram_control_one <= `EMI_RST_DRC1;
      dram_control_two <= `EMI_RST_DRC2;
      dram_refresh_period <= `EMI_RST_RFP;
      dram_refresh_extra <= `EMI_RST_RFX;
      dram_extension_one <= `EMI_RST_EXT1;
      dram_extension_two <= `EMI_RST_EXT2;
      clock_plan_sel <= 2'h0;
    end
    else if (clk_en && wr_fire)
    begin
      if (aw_idx == `EMI_IDX_GCTL1)
        global_control_one <= merge(global_control_one, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_GCTL2)
        global_control_two <= merge(global_control_two, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_S0T1)
        space0_timing_one <= merge(space0_timing_one, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_S0T2)
        space0_timing_two <= merge(space0_timing_two, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_FLT1)
        flash_space_timing_one <= merge(flash_space_timing_one, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_FLT2)
        flash_space_timing_two <= merge(flash_space_timing_two, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_LGT1)
        logic_space_timing_one <= merge(logic_space_timing_one, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_LGT2)
        logic_space_timing_two <= merge(logic_space_timing_two, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_DRC1)
        dram_control_one <= merge(dram_control_one, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_DRC2)
        dram_control_two <= merge(dram_control_two, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_RFP)
        dram_refresh_period <= merge(dram_refresh_period, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_RFX)
        dram_refresh_extra <= merge(dram_refresh_extra, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_EXT1)
        dram_extension_one <= merge(dram_extension_one, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_EXT2)
        dram_extension_two <= merge(dram_extension_two, w_data, w_strb);
      else if (aw_idx == `EMI_IDX_CLKPLAN && w_strb[0])
        clock_plan_sel <= w_data[1:0];
    end
  end

  // Read path; registers sit in the low half, upper bits read zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(reg_idx(s_axi_araddr)) ? 2'h0 : 2'h2;
        s_axi_rdata <= {16'h0000, read_mux(reg_idx(s_axi_araddr))};
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  function automatic logic [15:0] read_mux(input logic [15:0] i);
    if (i == `EMI_IDX_GCTL1) read_mux = global_control_one;
    else if (i == `EMI_IDX_GCTL2) read_mux = global_control_two;
    else if (i == `EMI_IDX_S0T1) read_mux = space0_timing_one;
    else if (i == `EMI_IDX_S0T2) read_mux = space0_timing_two;
    else if (i == `EMI_IDX_FLT1) read_mux = flash_space_timing_one;
    else if (i == `EMI_IDX_FLT2) read_mux = flash_space_timing_two;
    else if (i == `EMI_IDX_LGT1) read_mux = logic_space_timing_one;
    else if (i == `EMI_IDX_LGT2) read_mux = logic_space_timing_two;
    else if (i == `EMI_IDX_DRC1) read_mux = dram_control_one;
    else if (i == `EMI_IDX_DRC2) read_mux = dram_control_two;
    else if (i == `EMI_IDX_RFP) read_mux = dram_refresh_period;
    else if (i == `EMI_IDX_RFX) read_mux = dram_refresh_extra;
    else if (i == `EMI_IDX_EXT1) read_mux = dram_extension_one;
    else if (i == `EMI_IDX_EXT2) read_mux = dram_extension_two;
    else if (i == `EMI_IDX_CLKPLAN) read_mux = {14'h0000, clock_plan_sel};
    else if (i == `EMI_IDX_STATUS)
      read_mux = {10'h000, flash_sector, rdy_s2};
    else read_mux = 16'h0000;
  endfunction : read_mux

  // Clock plan: 0 boot, 1 kernel, 2 slower core with half-rate DRAM clock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clk_plan <= '{9'(`EMI_XTAL_MHZ), 9'(`EMI_BOOT_PERIPH_MHZ), 9'(`EMI_BOOT_PERIPH_MHZ),
                    9'(`EMI_BOOT_PERIPH_MHZ), 9'(`EMI_BOOT_PERIPH_MHZ)};
    else if (clk_en)
    begin
      if (clock_plan_sel == 2'h1)
        clk_plan <= '{9'(`EMI_CORE_MHZ), 9'(`EMI_FAST_MHZ), 9'(`EMI_SLOW_MHZ),
                      9'(`EMI_CORE_MHZ / `EMI_MEM_DIV),
                      9'(`EMI_CORE_MHZ / `EMI_MEM_DIV)};
      else if (clock_plan_sel == 2'h2)
        clk_plan <= '{9'(`EMI_ALT_CORE_MHZ), 9'(`EMI_FAST_MHZ), 9'(`EMI_SLOW_MHZ),
                      9'(`EMI_CORE_MHZ / `EMI_MEM_DIV),
                      9'(`EMI_DRAM_MAX_MHZ)};
      else
        clk_plan <= '{9'(`EMI_XTAL_MHZ), 9'(`EMI_BOOT_PERIPH_MHZ),
                      9'(`EMI_BOOT_PERIPH_MHZ), 9'(`EMI_BOOT_PERIPH_MHZ),
                      9'(`EMI_BOOT_PERIPH_MHZ)};
    end
  end

  // Ready/busy pin is asynchronous: two flops before use
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdy_s1 <= 1'b1;
      rdy_s2 <= 1'b1;
      flash_done_interrupt <= 1'b0;
    end
    else if (clk_en)
    begin
      rdy_s1 <= flash_ready_busy;
      rdy_s2 <= rdy_s1;
      flash_done_interrupt <= !rdy_s2;
    end
  end

  // Refresh timer counts memory clocks; self-refresh stops it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      refresh_count <= 16'h0000;
      refresh_request <= 1'b0;
    end
    else if (clk_en)
    begin
      refresh_request <= 1'b0;
      if (!dram_control_two[`EMI_DRC2_REFRESH_ENABLE_BIT_POS] ||
          dram_control_one[`EMI_DRC1_SELF_REFRESH_REQUEST_POS])
        refresh_count <= 16'h0000;
      else if (refresh_count >= dram_refresh_period - 16'h0001)
      begin
        refresh_count <= 16'h0000;
        refresh_request <= 1'b1;
      end
      else
        refresh_count <= refresh_count + 16'h0001;
    end
  end

  // Memory clock output gated by its enable field
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dram_clock_enable <= 1'b0;
    else if (clk_en)
      dram_clock_enable <= global_control_one[`EMI_GC1_FIRST_MEMCLK_ENABLE_POS];
  end

  assign core_req_ready = (state == EMI_ST_IDLE);

  // Access sequencer: flash single reads take a second paired access
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= EMI_ST_IDLE;
      cur <= '0;
      paired_left <= 2'h0;
      mem_space_select <= EMI_SP_NONE;
      mem_strobe <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 24'h000000;
      core_done <= 1'b0;
      flash_sector <= 5'h00;
    end
    else if (clk_en)
    begin
      core_done <= 1'b0;
      mem_strobe <= 1'b0;
      case (state)
        EMI_ST_IDLE:
        begin
          mem_space_select <= EMI_SP_NONE;
          if (core_req_valid)
          begin
            cur <= core_req;
            state <= EMI_ST_ACC;
          end
        end
        EMI_ST_ACC:
        begin
          mem_space_select <= space_of(cur.addr);
          mem_addr <= cur.addr;
          mem_write <= cur.write;
          mem_strobe <= (space_of(cur.addr) != EMI_SP_NONE);
          if (space_of(cur.addr) == EMI_SP_FLASH)
            flash_sector <= cur.addr[20:16];
          if (space_of(cur.addr) == EMI_SP_FLASH && !cur.write)
            state <= EMI_ST_PAIR;
          else
            state <= EMI_ST_DONE;
        end
        EMI_ST_PAIR:
        begin
          mem_addr <= cur.addr ^ 24'h000002;
          mem_strobe <= 1'b1;
          state <= EMI_ST_DONE;
        end
        EMI_ST_DONE:
        begin
          mem_space_select <= EMI_SP_NONE;
          core_done <= 1'b1;
          state <= EMI_ST_IDLE;
        end
        default:
          state <= EMI_ST_IDLE;
      endcase
    end
  end

endmodule : emi_setup
`default_nettype wire

// file: emi_setup_sva.sv
// Port assertions for emi_setup: decode, flash pairing, interrupt, refresh, clock plan.
// Assumes a bind from the bench, one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module emi_setup_sva
  import emi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] mem_space_select,
  input wire logic mem_strobe,
  input wire logic mem_write,
  input wire logic [23:0] mem_addr,
  input wire logic flash_ready_busy,
  input wire logic flash_done_interrupt,
  input wire logic refresh_request,
  input wire emi_clk_s clk_plan
);
  localparam int REF_GAP = 1171;
  logic [11:0] gap;
  logic seen;
  logic st_fl;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles since the last refresh; the first pulse after reset has no reference
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gap <= 12'h000;
      seen <= 1'b0;
    end
    else
    begin
      gap <= refresh_request ? 12'h000 : gap + 12'h001;
      seen <= seen | refresh_request;
    end
  end
  assign st_fl = mem_strobe && mem_space_select == EMI_SP_FLASH;
  property p_one_space; $onehot0(mem_space_select); endproperty
  a_one_space: assert property (p_one_space) else $error("select not one-hot");
  property p_dram_map; mem_strobe && mem_space_select == EMI_SP_DRAM |->
    mem_addr inside {[24'h010000:24'h3FFFFF]}; endproperty
  a_dram_map: assert property (p_dram_map) else $error("dram address out of range");
  property p_flash_map; st_fl |-> mem_addr inside {[24'h800000:24'h9FFFFF]}; endproperty
  a_flash_map: assert property (p_flash_map) else $error("flash address out of range");
  property p_logic_once; mem_strobe && mem_space_select == EMI_SP_LOGIC |->
    mem_addr >= 24'hC00000 ##1 !mem_strobe; endproperty
  a_logic_once: assert property (p_logic_once) else $error("logic space access");
  property p_flash_pair; st_fl && !mem_write && !$past(mem_strobe) |=>
    mem_strobe && mem_addr == ($past(mem_addr) ^ 24'h000002); endproperty
  a_flash_pair: assert property (p_flash_pair) else $error("no paired flash read");
  property p_flash_write; st_fl && mem_write |=> !mem_strobe; endproperty
  a_flash_write: assert property (p_flash_write) else $error("extra flash write");
  property p_irq; $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |->
    flash_done_interrupt == !$past(flash_ready_busy, 3); endproperty
  a_irq: assert property (p_irq) else $error("interrupt not inverse of ready");
  property p_refresh; refresh_request && seen |-> gap == REF_GAP; endproperty
  a_refresh: assert property (p_refresh) else $error("refresh spacing wrong");
  property p_plan; clk_plan.core_mhz == 9'h12C |->
    clk_plan.mem_mhz == 9'h04B && clk_plan.dram_clk_mhz == 9'h04B; endproperty
  a_plan: assert property (p_plan) else $error("memory clock not a quarter");
  c_pair: cover property (st_fl && !mem_write);
  c_refresh: cover property (refresh_request && seen);
  c_irq: cover property ($rose(flash_done_interrupt));
endmodule : emi_setup_sva
`default_nettype wire

// file: emi_mem_model.sv
// Flash ready/busy behaviour on the memory side of emi_setup.
// Assumes one clock; the bench sets how long a program access stays busy.
`timescale 1ns/1ns
`default_nettype none
module emi_mem_model
  import emi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] space_select,
  input wire logic strobe,
  input wire logic write,
  input wire logic [7:0] busy_len,
  output logic flash_ready_busy
);
  logic [7:0] busy_cnt;
  // Each program access holds the part busy; reads never do
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      busy_cnt <= 8'h00;
    else if (strobe && write && space_select == EMI_SP_FLASH)
      busy_cnt <= busy_len;
    else if (busy_cnt != 8'h00)
      busy_cnt <= busy_cnt - 8'h01;
  end
  // Pull-up holds the line at ready once the part is idle
  assign flash_ready_busy = (busy_cnt == 8'h00);
endmodule : emi_mem_model
`default_nettype wire

// file: tb.sv
// Bench for emi_setup: registers, clock plan, decode, flash pairing, refresh.
// Assumes the package, design, memory model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import emi_pkg::*;
  logic clk, rst_n, aw_v, aw_r, w_v, w_r, b_v, b_rdy, ar_v, ar_r, r_v, r_rdy;
  logic req_v, req_r, stb, m_wr, done, rb, irq, refr, dclk;
  logic [15:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, r32;
  logic [1:0] b_resp, r_resp, r2;
  logic [2:0] sel;
  logic [23:0] m_a;
  logic [4:0] sect;
  logic [7:0] busy_len;
  emi_req_s req;
  emi_clk_s plan;
  logic [27:0] seen_q[$];
  int fails, cmp_count, seed, n;
  logic [15:0] idx_t[14] = '{16'h0800, 16'h0801, 16'h0804, 16'h0805, 16'h0808, 16'h0809,
    16'h080A, 16'h080B, 16'h080C, 16'h080D, 16'h080E, 16'h080F, 16'h0810, 16'h0811};
  logic [15:0] rst_t[14] = '{16'h07FC, 16'h000A, 16'hFF33, 16'hFFFF, 16'hC811, 16'h11E2,
    16'hC422, 16'h2122, 16'h5000, 16'h4611, 16'h0494, 16'h0000, 16'h4527, 16'h0005};
  logic [23:0] edge_t[9] = '{24'h00FFFF, 24'h010000, 24'h3FFFFF, 24'h400000, 24'h800000,
    24'h9FFFFC, 24'hA00000, 24'hC00000, 24'hFFFFFF};
  emi_setup dut_u (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_rdy), .core_req(req), .core_req_valid(req_v), .core_req_ready(req_r),
    .mem_space_select(sel), .mem_strobe(stb), .mem_write(m_wr), .mem_addr(m_a),
    .core_done(done), .flash_ready_busy(rb), .flash_done_interrupt(irq),
    .flash_sector(sect), .refresh_request(refr), .dram_clock_enable(dclk), .clk_plan(plan));
  emi_mem_model mem_u (.clk(clk), .rst_n(rst_n), .space_select(sel), .strobe(stb),
    .write(m_wr), .busy_len(busy_len), .flash_ready_busy(rb));
  // Free-running 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Record every memory access as select, direction and address
  always @(posedge clk)
  begin
    if (stb)
      seen_q.push_back({sel, m_wr, m_a});
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    do
    begin
      @(posedge clk);
      if (aw_v && aw_r)
        aw_v <= 1'b0;
      if (w_v && w_r)
        w_v <= 1'b0;
    end
    while (!b_v);
    b_rdy <= 1'b0;
    r = b_resp;
  endtask : axi_wr
  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    do
    begin
      @(posedge clk);
      if (ar_v && ar_r)
        ar_v <= 1'b0;
    end
    while (!r_v);
    r_rdy <= 1'b0;
    d = r_d;
    r = r_resp;
  endtask : axi_rd
  function automatic logic [2:0] exp_sel(input logic [23:0] a);
    if (a >= 24'h010000 && a <= 24'h3FFFFF)
      return 3'h1;
    if (a >= 24'h800000 && a <= 24'h9FFFFF)
      return 3'h2;
    return (a >= 24'hC00000) ? 3'h4 : 3'h0;
  endfunction : exp_sel
  // One core access; strobes must follow the decode and the flash read pairing
  task automatic core_acc(input logic [23:0] a, input logic w);
    logic [2:0] s;
    int k;
    s = exp_sel(a);
    k = (s == 3'h0) ? 0 : (s == 3'h2 && !w) ? 2 : 1;
    @(posedge clk);
    seen_q.delete();
    req <= {a, w, 32'($random(seed))};
    req_v <= 1'b1;
    do
      @(posedge clk);
    while (!req_r);
    req_v <= 1'b0;
    do
      @(posedge clk);
    while (!done);
    chk("strobes", k, seen_q.size());
    for (int j = 0; j < k; j++)
      chk("access", {s, w, ((j == 1) ? a ^ 24'h000002 : a)}, seen_q[j]);
    if (s == 3'h2)
      chk("sector", a[20:16], sect);
  endtask : core_acc
  task automatic sweep;
    for (int i = 0; i < 14; i++)
    begin
      axi_rd({idx_t[i][13:0], 2'b00}, r32, r2);
      chk("reg", {16'h0000, rst_t[i]}, r32);
    end
  endtask : sweep
  // Edges until the next refresh pulse, bounded so a silent refresh shows up
  task automatic to_refresh;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!refr && n < 1300);
  endtask : to_refresh
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  initial
  begin
    seed = 32'h0a55;
    {aw_v, w_v, b_rdy, ar_v, r_rdy, req_v} = 6'h00;
    {aw_a, ar_a, w_d} = 64'h0;
    req = 57'h0;
    busy_len = 8'h01;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("plan", {9'h014, {4{9'h005}}}, plan);
    chk("memclk enable", 1'b1, dclk);
    sweep();
    axi_rd(16'h3000, r32, r2);
    chk("unmapped rresp", 2'b10, r2);
    axi_wr(16'h3000, 32'h0000_1234, r2);
    chk("unmapped bresp", 2'b10, r2);
    // Random words into the space timing registers; the upper half is dropped
    for (int i = 2; i < 8; i++)
    begin
      n = $random(seed);
      axi_wr({idx_t[i][13:0], 2'b00}, n, r2);
      axi_rd({idx_t[i][13:0], 2'b00}, r32, r2);
      chk("rw", {16'h0000, n[15:0]}, r32);
    end
    axi_wr(16'h2034, 32'h0000_4711, r2);
    axi_rd(16'h2034, r32, r2);
    chk("init word", 32'h0000_4711, r32);
    $display("done: registers");
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    sweep();
    $display("done: second reset");
    axi_wr(16'h2080, 32'h1, r2);
    repeat (2) @(posedge clk);
    chk("plan", {9'h12C, 9'h096, 9'h04B, 9'h04B, 9'h04B}, plan);
    axi_wr(16'h2080, 32'h2, r2);
    repeat (2) @(posedge clk);
    chk("core clock", 9'h0C8, plan.core_mhz);
    chk("dram clock", 9'h064, plan.dram_clk_mhz);
    axi_wr(16'h2080, 32'h1, r2);
    $display("done: clock plan");
    for (int i = 0; i < 18; i++)
      core_acc(edge_t[i / 2], i[0]);
    for (int i = 0; i < 30; i++)
    begin
      n = $random(seed);
      core_acc(n[23:0], n[24]);
    end
    $display("done: decode");
    busy_len <= 8'h28;
    core_acc(24'h820000, 1'b1);
    axi_rd(16'h2084, r32, r2);
    chk("status", 6'h04, r32[5:0]);
    chk("irq busy", 1'b1, irq);
    repeat (50) @(posedge clk);
    chk("irq idle", 1'b0, irq);
    $display("done: flash busy");
    to_refresh();
    to_refresh();
    chk("refresh gap", 1172, n);
    $display("done: refresh");
    report_and_stop();
  end
endmodule : tb
bind emi_setup emi_setup_sva chk_u (.clk(clk), .rst_n(rst_n),
  .mem_space_select(mem_space_select), .mem_strobe(mem_strobe), .mem_write(mem_write),
  .mem_addr(mem_addr), .flash_ready_busy(flash_ready_busy),
  .flash_done_interrupt(flash_done_interrupt), .refresh_request(refresh_request),
  .clk_plan(clk_plan));
`default_nettype wire
